// ==== design/imu_ctrl_regs.svh ====
// Constants of the IMU trigger and sync control
`ifndef IMU_CTRL_REGS_SVH
`define IMU_CTRL_REGS_SVH

`define CLK_HZ 20000000
`define MAX_SAMPLE_HZ 2000
// Cycles per sample at the maximum rate
`define SAMPLE_CYCLES (`CLK_HZ / `MAX_SAMPLE_HZ)
`define INIT_DGRAM_COUNT 3
`define STATUS_STARTUP_BIT 6
`define STATUS_AUX_BIT 0
`define STARTUP_CYCLES 20000
`define SETTLE_CYCLES 1000
`define AUX_WIDTH 24
`define COEF_WIDTH 16
`define COEF_FRAC 14
`define GAIN_RESET 16'h4000
`define OFFSET_RESET 16'h0000
`define FILTER_SHIFT_RESET 4'h2

`endif

// ==== design/imu_ctrl_pkg.sv ====
// Types shared by the IMU trigger and sync control
package imu_ctrl_pkg;

    typedef enum logic [1:0] {
        MODE_INIT = 2'b00,
        MODE_NORMAL = 2'b01,
        MODE_SERVICE = 2'b10
    } mode_t;

    typedef enum logic [2:0] {
        DG_NONE = 3'b000,
        DG_PART = 3'b001,
        DG_SERIAL = 3'b010,
        DG_CONFIG = 3'b011,
        DG_MEAS = 3'b100
    } dgram_kind_t;

    typedef struct packed {
        dgram_kind_t kind;
        logic [23:0] aux;
        logic [7:0] status;
    } dgram_req_t;

    typedef struct packed {
        logic [15:0] gain;
        logic [15:0] offset;
        logic [3:0] filt_shift;
    } aux_cfg_t;

endpackage

// ==== design/pin_sync.sv ====
// Three-stage pin synchroniser with agreement check
module pin_sync (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic pin_in,
    output logic level_out,
    output logic fall_out
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } sync_state_t;

    sync_state_t q, d;

    always_comb begin
        d = q;
        d.s1 = pin_in;
        d.s2 = q.s1;
        d.s3 = q.s2;
        if (q.s2 == q.s3) begin
            d.level = q.s3;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            q <= 4'hF;
        end else begin
            q <= d;
        end
    end

    assign level_out = q.level;
    assign fall_out = q.level & ~d.level;
endmodule

// ==== design/req_buffer.sv ====
// Two-entry buffer of datagram requests toward the serial transmitter
module req_buffer (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire imu_ctrl_pkg::dgram_req_t in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output imu_ctrl_pkg::dgram_req_t out_data_out
);
    typedef struct packed {
        imu_ctrl_pkg::dgram_req_t [1:0] mem;
        logic rd;
        logic wr;
        logic [1:0] cnt;
    } buf_state_t;

    buf_state_t q, d;
    logic push, pop;

    assign in_ready_out = (q.cnt != 2'd2);
    assign out_valid_out = (q.cnt != 2'd0);
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wr] = in_data_in;
            d.wr = ~q.wr;
        end
        if (pop) begin
            d.rd = ~q.rd;
        end
        d.cnt = 2'(q.cnt + {1'b0, push} - {1'b0, pop});
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign out_data_out = q.mem[q.rd];
endmodule

// ==== design/imu_trigger_sync_control.sv ====
// Top of the IMU transmit, trigger and strobe control
`include "imu_ctrl_regs.svh"

module imu_trigger_sync_control #(
    parameter int SAMPLE_CYCLES = `SAMPLE_CYCLES,
    parameter int STARTUP_CYCLES = `STARTUP_CYCLES,
    parameter int SETTLE_CYCLES = `SETTLE_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic active_low_reset_input_in,
    input wire logic transmit_trigger_input_in,
    input wire logic trigger_only_in,
    input wire logic config_request_command_in,
    input wire logic service_cfg_wr_in,
    input wire imu_ctrl_pkg::aux_cfg_t service_cfg_in,
    input wire logic aux_sample_valid_in,
    input wire logic [23:0] aux_raw_in,
    input wire logic [2:0] sensor_status_in,
    output logic tx_req_valid_out,
    input wire logic tx_req_ready_in,
    output imu_ctrl_pkg::dgram_req_t tx_req_out,
    input wire logic tx_done_in,
    output logic validity_strobe_out,
    output logic sample_tick_out,
    output imu_ctrl_pkg::mode_t mode_out,
    output logic startup_flag_out,
    output logic [23:0] aux_filtered_out
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        imu_ctrl_pkg::mode_t mode;
        logic [1:0] init_sent;
        logic [1:0] init_done;
        logic [15:0] settle_cnt;
        logic [15:0] samp_cnt;
        logic [31:0] startup_cnt;
        logic startup;
        logic strobe;
        logic [1:0] in_flight;
        logic pend_cfg;
        logic pend_meas;
        imu_ctrl_pkg::aux_cfg_t cfg;
        logic [23:0] aux_comp;
        logic [23:0] aux_filt;
    } ctrl_state_t;

    ctrl_state_t q, d;

    logic rst_level, rst_fall, trig_level, trig_fall;
    logic push, ready;
    imu_ctrl_pkg::dgram_req_t req;
    logic sample_tick;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [23:0] comp_aux(input logic [23:0] raw,
                                              input logic [15:0] gain,
                                              input logic [15:0] offs);
        logic signed [40:0] prod;
        logic signed [40:0] sum;
        prod = 41'(signed'(raw) * signed'(gain));
        sum = (prod >>> `COEF_FRAC) + 41'(signed'(offs));
        return sum[23:0];
    endfunction

    function automatic logic [23:0] lp_step(input logic [23:0] acc,
                                            input logic [23:0] x,
                                            input logic [3:0] sh);
        logic signed [24:0] diff;
        diff = 25'(signed'(x)) - 25'(signed'(acc));
        return 24'(signed'(acc) + 24'(diff >>> sh));
    endfunction

    // ------------------------------------------------------------
    // Pins and buffer
    // ------------------------------------------------------------
    pin_sync u_rst_sync (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .pin_in(active_low_reset_input_in),
        .level_out(rst_level),
        .fall_out(rst_fall)
    );

    pin_sync u_trig_sync (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .pin_in(transmit_trigger_input_in),
        .level_out(trig_level),
        .fall_out(trig_fall)
    );

    req_buffer u_buf (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .in_valid_in(push),
        .in_ready_out(ready),
        .in_data_in(req),
        .out_valid_out(tx_req_valid_out),
        .out_ready_in(tx_req_ready_in),
        .out_data_out(tx_req_out)
    );

    assign sample_tick = (q.samp_cnt == 16'(SAMPLE_CYCLES - 1));

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        push = 1'b0;
        req = '0;
        req.status = {q.startup, 1'b0, 1'b0, 1'b0, 1'b0, sensor_status_in};
        req.aux = q.aux_filt;
        d.samp_cnt = sample_tick ? 16'h0000 : 16'(q.samp_cnt + 16'h0001);

        if (service_cfg_wr_in && q.mode == imu_ctrl_pkg::MODE_SERVICE) begin
            d.cfg = service_cfg_in;
        end
        if (aux_sample_valid_in) begin
            d.aux_comp = comp_aux(aux_raw_in, q.cfg.gain, q.cfg.offset);
            d.aux_filt = lp_step(q.aux_filt, q.aux_comp, q.cfg.filt_shift);
        end

        if (trig_fall && trigger_only_in) begin
            d.pend_meas = 1'b1;
        end
        if (config_request_command_in) begin
            d.pend_cfg = 1'b1;
        end
        if (q.startup_cnt != 32'h0) begin
            d.startup_cnt = 32'(q.startup_cnt - 32'h1);
        end else begin
            d.startup = 1'b0;
        end

        case (q.mode)
            imu_ctrl_pkg::MODE_INIT: begin
                if (q.settle_cnt != 16'h0) begin
                    d.settle_cnt = 16'(q.settle_cnt - 16'h1);
                end else if (q.init_sent < 2'(`INIT_DGRAM_COUNT) && ready) begin
                    push = 1'b1;
                    req.kind = imu_ctrl_pkg::dgram_kind_t'(3'(q.init_sent) + 3'h1);
                    d.init_sent = 2'(q.init_sent + 2'h1);
                end
                if (tx_done_in) begin
                    d.init_done = 2'(q.init_done + 2'h1);
                end
                if (d.init_done == 2'(`INIT_DGRAM_COUNT)) begin
                    d.mode = imu_ctrl_pkg::MODE_NORMAL;
                    d.startup = 1'b1;
                    d.startup_cnt = 32'(STARTUP_CYCLES);
                    d.pend_cfg = 1'b0;
                    d.pend_meas = 1'b0;
                end
            end
            imu_ctrl_pkg::MODE_NORMAL: begin
                if (q.pend_cfg && ready) begin
                    push = 1'b1;
                    req.kind = imu_ctrl_pkg::DG_CONFIG;
                    d.pend_cfg = config_request_command_in;
                end else if (ready && ((trigger_only_in && q.pend_meas) ||
                                       (!trigger_only_in && sample_tick))) begin
                    push = 1'b1;
                    req.kind = imu_ctrl_pkg::DG_MEAS;
                    d.pend_meas = trig_fall && trigger_only_in;
                end
            end
            default: begin
                d.mode = imu_ctrl_pkg::MODE_SERVICE;
            end
        endcase

        if (push && !tx_done_in) begin
            d.in_flight = 2'(q.in_flight + 2'h1);
        end else if (!push && tx_done_in && q.in_flight != 2'h0) begin
            d.in_flight = 2'(q.in_flight - 2'h1);
        end

        if (sample_tick) begin
            d.strobe = 1'b1;
        end else if (trigger_only_in) begin
            d.strobe = 1'b0;
        end else if (q.strobe && d.in_flight == 2'h0 && !push) begin
            d.strobe = 1'b0;
        end

        if (!rst_level || rst_fall) begin
            d = '0;
            d.mode = imu_ctrl_pkg::MODE_INIT;
            d.settle_cnt = 16'(SETTLE_CYCLES);
            d.cfg = q.cfg;
            push = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            q <= '0;
            q.mode <= imu_ctrl_pkg::MODE_INIT;
            q.settle_cnt <= 16'(SETTLE_CYCLES);
            q.cfg.gain <= `GAIN_RESET;
            q.cfg.offset <= `OFFSET_RESET;
            q.cfg.filt_shift <= `FILTER_SHIFT_RESET;
        end else begin
            q <= d;
        end
    end

    assign validity_strobe_out = q.strobe;
    assign sample_tick_out = sample_tick;
    assign mode_out = q.mode;
    assign startup_flag_out = q.startup;
    assign aux_filtered_out = q.aux_filt;
endmodule

// ==== sim/imu_ctrl_chk.sv ====
// Port assertions of the trigger, strobe and mode control
module imu_ctrl_chk #(
    parameter int SAMPLE_CYCLES = 20,
    parameter int STARTUP_CYCLES = 50
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic active_low_reset_input_in,
    input wire logic trigger_only_in,
    input wire logic tx_req_valid_out,
    input wire logic tx_req_ready_in,
    input wire imu_ctrl_pkg::dgram_req_t tx_req_out,
    input wire logic validity_strobe_out,
    input wire logic sample_tick_out,
    input wire imu_ctrl_pkg::mode_t mode_out,
    input wire logic startup_flag_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    // ----
    // Counters for spans too long to unroll
    // ----
    logic [15:0] tick_q;
    logic [15:0] up_q;
    logic seen_q;
    always_ff @(posedge ref_clk_in) begin
        tick_q <= sample_tick_out ? 16'h0000 : tick_q + 16'h0001;
        up_q <= startup_flag_out ? up_q + 16'h0001 : 16'h0000;
        // Pin reset may restart the sample counter
        seen_q <= rst_n_in && active_low_reset_input_in && (seen_q || sample_tick_out);
    end
    property p_tick_gap;
        sample_tick_out && seen_q |-> tick_q == SAMPLE_CYCLES - 1;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("tick spacing wrong");
    property p_tick_strobe;
        sample_tick_out && active_low_reset_input_in |=> validity_strobe_out;
    endproperty
    a_tick_strobe: assert property (p_tick_strobe) else $error("strobe missed tick");
    property p_rise_src;
        $rose(validity_strobe_out) |-> $past(sample_tick_out);
    endproperty
    a_rise_src: assert property (p_rise_src) else $error("strobe rose off tick");
    property p_trig_fall;
        trigger_only_in && validity_strobe_out |=> !validity_strobe_out;
    endproperty
    a_trig_fall: assert property (p_trig_fall) else $error("strobe held");
    property p_hold;
        tx_req_valid_out && !tx_req_ready_in |=> tx_req_valid_out && $stable(tx_req_out);
    endproperty
    a_hold: assert property (p_hold) else $error("request dropped");
    property p_pin;
        !active_low_reset_input_in [*6] |-> mode_out == imu_ctrl_pkg::MODE_INIT;
    endproperty
    a_pin: assert property (p_pin) else $error("pin reset ignored");
    property p_norm;
        $rose(mode_out == imu_ctrl_pkg::MODE_NORMAL) |-> ##[0:1] startup_flag_out;
    endproperty
    a_norm: assert property (p_norm) else $error("startup flag not set");
    property p_up;
        startup_flag_out |-> up_q <= STARTUP_CYCLES;
    endproperty
    a_up: assert property (p_up) else $error("startup flag too long");
endmodule

// ==== sim/tx_model.sv ====
// Serial transmitter stand-in: takes a request, reports its last bit later
module tx_model (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic valid_in,
    input wire logic slow_in,
    output logic ready_out,
    output logic done_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_q;
    logic busy_q;
    assign ready_out = !busy_q && cnt_q == 4'h0;
    always_ff @(posedge ref_clk_in) begin
        done_out <= 1'b0;
        if (!rst_n_in) begin
            busy_q <= 1'b0;
            cnt_q <= 4'h0;
        end else if (busy_q) begin
            cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h0) begin
                busy_q <= 1'b0;
                done_out <= 1'b1;
                // Slow gap plus busy time outlasts a 20-cycle sample, so the buffer backs up
                cnt_q <= slow_in ? 4'hF : 4'h0;
            end
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end else if (valid_in) begin
            busy_q <= 1'b1;
            cnt_q <= 4'h9;
        end
    end
endmodule

// ==== sim/tb.sv ====
// Self-checking bench of the trigger, strobe and mode control
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n, pin_n, trig, trig_only, cfg, slow, valid, ready, done;
    logic strobe, tick, flag;
    logic aux_valid = 1'b0;
    logic [23:0] aux_raw = 24'h001000;
    logic [2:0] sens = 3'h0;
    logic [23:0] aux_out;
    imu_ctrl_pkg::mode_t mode;
    imu_ctrl_pkg::dgram_req_t req;
    imu_ctrl_pkg::dgram_kind_t kinds[$];
    int fail_count = 0;
    int n_tests = 0;
    always #25 clk = ~clk;
    always @(posedge clk) if (valid && ready) kinds.push_back(req.kind);
    imu_trigger_sync_control #(
        .SAMPLE_CYCLES(20),
        .STARTUP_CYCLES(50),
        .SETTLE_CYCLES(5)
    ) u_dut (
        .ref_clk_in(clk), .rst_n_in(rst_n), .active_low_reset_input_in(pin_n),
        .transmit_trigger_input_in(trig), .trigger_only_in(trig_only),
        .config_request_command_in(cfg), .service_cfg_wr_in(1'b0), .service_cfg_in('0),
        .aux_sample_valid_in(aux_valid), .aux_raw_in(aux_raw), .sensor_status_in(sens),
        .tx_req_valid_out(valid), .tx_req_ready_in(ready), .tx_req_out(req),
        .tx_done_in(done), .validity_strobe_out(strobe), .sample_tick_out(tick),
        .mode_out(mode), .startup_flag_out(flag), .aux_filtered_out(aux_out)
    );
    tx_model u_tx (.ref_clk_in(clk), .rst_n_in(rst_n), .valid_in(valid),
        .slow_in(slow), .ready_out(ready), .done_out(done));
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s exp %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wait_kinds(input int n);
        for (int i = 0; i < 400 && kinds.size() < n; i++) @(negedge clk);
        if (kinds.size() < n) begin
            fail_count++;
            tally_and_finish();
        end
    endtask
    // Identity datagrams, then normal mode with start-up flag
    task automatic t_ident();
        imu_ctrl_pkg::dgram_kind_t exp[3];
        exp = '{imu_ctrl_pkg::DG_PART, imu_ctrl_pkg::DG_SERIAL, imu_ctrl_pkg::DG_CONFIG};
        wait_kinds(3);
        foreach (exp[i]) check("ident", 8'(kinds[i]), 8'(exp[i]));
        repeat (15) @(negedge clk);
        check("mode", 8'(mode), 8'(imu_ctrl_pkg::MODE_NORMAL));
        check("startup", 8'(flag), 8'h01);
        repeat (60) @(negedge clk);
        check("startup", 8'(flag), 8'h00);
        check("idle count", 8'(kinds.size()), 8'h03);
    endtask
    task automatic t_trig(input int n);
        kinds.delete();
        repeat (n) begin
            trig = 1'b0;
            repeat (6) @(negedge clk);
            trig = 1'b1;
            repeat (30) @(negedge clk);
        end
        check("trig count", 8'(kinds.size()), 8'(n));
        foreach (kinds[i]) check("trig kind", 8'(kinds[i]), 8'(imu_ctrl_pkg::DG_MEAS));
    endtask
    // Config request beside a trigger: config goes first
    task automatic t_cfg();
        kinds.delete();
        trig = 1'b0;
        cfg = 1'b1;
        @(negedge clk);
        cfg = 1'b0;
        repeat (6) @(negedge clk);
        trig = 1'b1;
        wait_kinds(2);
        check("cfg kind", 8'(kinds[0]), 8'(imu_ctrl_pkg::DG_CONFIG));
        check("meas kind", 8'(kinds[1]), 8'(imu_ctrl_pkg::DG_MEAS));
    endtask
    task automatic t_pin();
        repeat (30) @(negedge clk);
        kinds.delete();
        pin_n = 1'b0;
        repeat (8) @(negedge clk);
        check("pin mode", 8'(mode), 8'(imu_ctrl_pkg::MODE_INIT));
        pin_n = 1'b1;
        t_ident();
    endtask
    // Free run against a slow transmitter
    task automatic t_free();
        kinds.delete();
        slow = 1'b1;
        sens = 3'h5;
        trig_only = 1'b0;
        repeat (200) @(negedge clk);
        check("status", 8'(req.status), 8'h05);
        check("free count", 8'(kinds.size() >= 5), 8'h01);
        foreach (kinds[i]) check("free kind", 8'(kinds[i]), 8'(imu_ctrl_pkg::DG_MEAS));
    endtask
    initial begin
        rst_n = 1'b0;
        pin_n = 1'b1;
        trig = 1'b1;
        trig_only = 1'b1;
        cfg = 1'b0;
        slow = 1'b0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        // Unity gain, shift 2: second sample moves filter a quarter
        aux_valid = 1'b1;
        repeat (2) @(negedge clk);
        aux_valid = 1'b0;
        check("aux filt", 8'(aux_out[15:8]), 8'h04);
        t_ident();
        t_trig(1);
        t_trig(2);
        t_cfg();
        t_pin();
        t_free();
        tally_and_finish();
    end
endmodule
bind imu_trigger_sync_control imu_ctrl_chk #(
    .SAMPLE_CYCLES(SAMPLE_CYCLES),
    .STARTUP_CYCLES(STARTUP_CYCLES)
) u_chk (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .active_low_reset_input_in(active_low_reset_input_in), .trigger_only_in(trigger_only_in),
    .tx_req_valid_out(tx_req_valid_out), .tx_req_ready_in(tx_req_ready_in),
    .tx_req_out(tx_req_out), .validity_strobe_out(validity_strobe_out),
    .sample_tick_out(sample_tick_out), .mode_out(mode_out), .startup_flag_out(startup_flag_out)
);
